// *** hw/amp_tracker.sv ***
// Purpose: per-channel working drive code for amplitude correction and calibration
// Assumes: comparator flags are synchronised; step is one cycle per finished conversion
// Notes:   one code step per conversion, so the output never jumps mid-conversion

`timescale 1ns/1ps

module amp_tracker
    import drive_ctrl_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic enable,
    input wire logic step,
    input wire logic [1:0] channel,
    // amplitude comparators (above 1.8 V, below 1.2 V)
    input wire logic above,
    input wire logic below,
    // working codes
    output logic [3:0][4:0] code
);

    logic [4:0] cur;
    assign cur = code[channel];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            code <= {4{work_code_reset}};
        end else if (enable && step) begin
            if (above && !below && cur != code_off) begin
                code[channel] <= cur - 5'h01;
            end else if (below && !above && cur != code_full) begin
                code[channel] <= cur + 5'h01;
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    amp_lower_a: assert property (
        enable && step && above && !below && cur != code_off
        |=> code[$past(channel)] == $past(cur) - 5'h01)
        else $error("drive code not lowered on high amplitude");

    amp_raise_a: assert property (
        enable && step && below && !above && cur != code_full
        |=> code[$past(channel)] == $past(cur) + 5'h01)
        else $error("drive code not raised on low amplitude");

    amp_frozen_a: assert property (
        !enable |=> $stable(code))
        else $error("working code moved while correction is off");

endmodule

// *** hw/drive_ctrl_pkg.sv ***
// Purpose: shared constants, types and helpers for the sensor drive current control block
// Assumes: register word index = byte address / 4, 32-bit AXI4-Lite data
// Notes:   register indices, field positions, codes and the cfg, ctrl and drive code reset values live here

package drive_ctrl_pkg;

    // ************************************************************
    // register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [5:0] idx_config = 6'h1a;
    localparam logic [5:0] idx_drive0 = 6'h1e;
    localparam logic [5:0] idx_drive3 = 6'h21;
    localparam logic [5:0] idx_control = 6'h22;
    localparam logic [5:0] idx_status = 6'h23;
    localparam logic [5:0] idx_sample = 6'h24;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int cfg_boost_pos = 6;
    localparam int cfg_amp_dis_pos = 10;
    localparam int cfg_act_sel_pos = 11;
    localparam int cfg_override_pos = 12;
    localparam int code_pos = 11;
    localparam int init_pos = 6;
    localparam int ctrl_sleep_pos = 0;
    localparam int ctrl_multi_pos = 1;

    // ************************************************************
    // codes and reset values
    // ************************************************************
    localparam logic [4:0] code_full = 5'h1f;
    localparam logic [4:0] code_off = 5'h00;
    localparam logic [4:0] drive_reset = 5'h00;
    localparam logic [4:0] work_code_reset = 5'h10;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_decerr = 2'h3;

    typedef struct packed {
        logic override;
        logic act_sel;
        logic amp_dis;
        logic boost;
    } cfg_s;
    localparam cfg_s cfg_reset = '{override: 1'b0, act_sel: 1'b0, amp_dis: 1'b0, boost: 1'b0};

    typedef struct packed {
        logic multi;
        logic sleep;
    } ctrl_s;
    // the device comes up asleep and waits for configuration
    localparam ctrl_s ctrl_reset = '{multi: 1'b0, sleep: 1'b1};

    typedef struct packed {
        logic alive;
        logic below;
        logic above;
    } tank_s;

    typedef enum logic [2:0] {
        ph_sleep = 3'b001,
        ph_settle = 3'b010,
        ph_convert = 3'b100
    } phase_e;

    // nominal drive current in microamps, one entry per code
    localparam logic [10:0] ua_table [0:31] = '{
        11'h010, 11'h012, 11'h014, 11'h017, 11'h01c, 11'h020, 11'h028, 11'h02e,
        11'h034, 11'h03b, 11'h048, 11'h052, 11'h05f, 11'h06e, 11'h07f, 11'h092,
        11'h0a9, 11'h0c3, 11'h0d4, 11'h0f4, 11'h129, 11'h156, 11'h1a8, 11'h1e9,
        11'h227, 11'h27b, 11'h2fb, 11'h370, 11'h3f9, 11'h495, 11'h54b, 11'h61b
    };

    function automatic logic [10:0] nominal_ua(input logic [4:0] code);
        return ua_table[code];
    endfunction

endpackage

// *** hw/drive_current_ctrl.sv ***
// Purpose: sensor drive current control with AXI4-Lite register access
// Assumes: converter sequencer shares aclk; tank comparators and alive flag are asynchronous
// Notes:   registers sit at byte address four times their word index
//
// Operation
// - correction keeps amplitude between 1.2V and 1.8V
// - boost only on channel 0, single-channel
// - activation select bit 11, b0 full current
// - override bit 12: b1 fixed if bit 10 b1, else corrected; b0 calibrate
// - bit 10 b1 disables amplitude correction
// - drive code 15:11 used when fixed
// - initial drive 10:6 written by device only
// - drive registers at 0x1e to 0x21
// - drive code maps monotonically to current
// - dead oscillation reports all-zero samples
// - sleep stops conversions, keeps configuration

`timescale 1ns/1ps

module drive_current_ctrl
    import drive_ctrl_pkg::*;
#(
    parameter bit four_channel = 1'b1
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // converter sequencer
    input wire logic conv_settling,
    input wire logic conv_done,
    input wire logic [1:0] conv_channel,
    input wire logic [11:0] conv_sample,
    output logic sleep_mode,
    output logic [11:0] sample_data,
    output logic [1:0] sample_channel,
    output logic sample_valid,
    // sensor tank
    input wire logic amp_above_max,
    input wire logic amp_below_min,
    input wire logic osc_alive,
    output logic [4:0] drive_code,
    output logic drive_enable,
    output logic boosted_drive_ch0
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic ch_present(input logic [1:0] ch);
        return four_channel || !ch[1];
    endfunction

    function automatic logic is_mapped(input logic [5:0] idx);
        logic hit;
        hit = 1'b0;
        case (idx)
            idx_config, idx_control, idx_status, idx_sample: hit = 1'b1;
            default: begin
                if (idx >= idx_drive0 && idx <= idx_drive3) begin
                    hit = ch_present(2'(idx - idx_drive0));
                end
            end
        endcase
        return hit;
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    cfg_s cfg;
    ctrl_s ctrl;
    tank_s tank;
    phase_e phase;
    phase_e next_phase;
    logic [4:0] prog_code [0:3];
    logic [4:0] init_code [0:3];
    logic [3:0][4:0] work_code;
    logic [4:0] work_cur;
    logic [4:0] prog_cur;
    logic [4:0] fixed_code;
    logic [4:0] next_drive;
    logic [15:0] cfg_word;
    logic [10:0] applied_ua;
    logic [19:0] init_flat;
    logic conv_ok;
    logic loop_enable;
    logic aw_held;
    logic w_held;
    logic [5:0] wr_idx;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_go;
    logic [5:0] ar_idx;
    logic [1:0] rd_ch;
    logic [1:0] wr_ch;
    logic [31:0] rd_word;

    assign conv_ok = conv_done && !ctrl.sleep && ch_present(conv_channel);
    assign work_cur = work_code[conv_channel];
    assign prog_cur = prog_code[conv_channel];
    assign applied_ua = nominal_ua(drive_code);
    assign init_flat = {init_code[3], init_code[2], init_code[1], init_code[0]};
    assign cfg_word = {3'h0, cfg.override, cfg.act_sel, cfg.amp_dis, 3'h0, cfg.boost, 6'h00};
    assign wr_go = aw_held && w_held && !bvalid;
    assign ar_idx = araddr[7:2];
    assign rd_ch = 2'(ar_idx - idx_drive0);
    assign wr_ch = 2'(wr_idx - idx_drive0);
    // calibration and amplitude correction share one search loop
    assign loop_enable = !cfg.amp_dis || !cfg.override;

    // ************************************************************
    // input synchronisation and amplitude loop
    // ************************************************************
    sync3 #(
        .width(3)
    ) u_tank_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({osc_alive, amp_below_min, amp_above_max}),
        .sync_out(tank)
    );

    amp_tracker u_amp (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(loop_enable),
        .step(conv_ok),
        .channel(conv_channel),
        .above(tank.above),
        .below(tank.below),
        .code(work_code)
    );

    // ************************************************************
    // axi4-lite write path
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_idx <= 6'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= resp_okay;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                awready <= 1'b0;
                wr_idx <= awaddr[7:2];
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                wready <= 1'b0;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= is_mapped(wr_idx) ? resp_okay : resp_decerr;
            end else if (bvalid && bready) begin
                // only one write is in flight; reopen both channels now
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // ************************************************************
    // axi4-lite read path
    // ************************************************************
    always_comb begin
        rd_word = 32'h0000_0000;
        case (ar_idx)
            idx_config: rd_word[15:0] = cfg_word;
            idx_control: rd_word[1:0] = ctrl;
            idx_status: rd_word = {14'h0000, boosted_drive_ch0, tank.alive, applied_ua, drive_code};
            idx_sample: rd_word[13:0] = {sample_channel, sample_data};
            default: begin
                if (is_mapped(ar_idx)) begin
                    rd_word[15:0] = {prog_code[rd_ch], init_code[rd_ch], 6'h00};
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= resp_okay;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= is_mapped(ar_idx) ? resp_okay : resp_decerr;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ************************************************************
    // configuration and control registers
    // ************************************************************
    // sleep does not touch these, so configuration survives it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg <= cfg_reset;
        end else if (wr_go && wr_idx == idx_config) begin
            if (w_strb_q[0]) begin
                cfg.boost <= w_data_q[cfg_boost_pos];
            end
            if (w_strb_q[1]) begin
                cfg.amp_dis <= w_data_q[cfg_amp_dis_pos];
                cfg.act_sel <= w_data_q[cfg_act_sel_pos];
                cfg.override <= w_data_q[cfg_override_pos];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= ctrl_reset;
        end else if (wr_go && wr_idx == idx_control && w_strb_q[0]) begin
            ctrl.sleep <= w_data_q[ctrl_sleep_pos];
            ctrl.multi <= w_data_q[ctrl_multi_pos];
        end
    end

    // ************************************************************
    // per-channel drive registers
    // ************************************************************
    // the initial drive field has no software write path at all
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 4; i++) begin
                prog_code[i] <= drive_reset;
            end
        end else if (wr_go && is_mapped(wr_idx) && wr_idx >= idx_drive0 && wr_idx <= idx_drive3
                     && w_strb_q[1]) begin
            prog_code[wr_ch] <= w_data_q[code_pos+4:code_pos];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 4; i++) begin
                init_code[i] <= drive_reset;
            end
        end else if (conv_ok && !cfg.override) begin
            init_code[conv_channel] <= work_cur;
        end
    end

    // ************************************************************
    // drive output
    // ************************************************************
    always_comb begin
        next_phase = ph_convert;
        if (ctrl.sleep) begin
            next_phase = ph_sleep;
        end else if (conv_settling) begin
            next_phase = ph_settle;
        end
        fixed_code = (cfg.amp_dis && cfg.override) ? prog_cur : work_cur;
        case (next_phase)
            ph_sleep: next_drive = code_off;
            ph_settle: next_drive = cfg.act_sel ? fixed_code : code_full;
            ph_convert: next_drive = fixed_code;
            default: next_drive = code_off;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase <= ph_sleep;
            drive_code <= code_off;
            drive_enable <= 1'b0;
            sleep_mode <= 1'b1;
        end else begin
            phase <= next_phase;
            drive_code <= next_drive;
            drive_enable <= next_phase != ph_sleep;
            sleep_mode <= ctrl.sleep;
        end
    end

    // boost is ignored rather than obeyed in multi-channel mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            boosted_drive_ch0 <= 1'b0;
        end else begin
            boosted_drive_ch0 <= cfg.boost && !ctrl.multi && !ctrl.sleep
                                 && conv_channel == 2'h0;
        end
    end

    // ************************************************************
    // sample output
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sample_data <= 12'h000;
            sample_channel <= 2'h0;
            sample_valid <= 1'b0;
        end else begin
            sample_valid <= 1'b0;
            if (ctrl.sleep) begin
                sample_data <= 12'h000;
            end else if (conv_ok) begin
                sample_valid <= 1'b1;
                sample_channel <= conv_channel;
                sample_data <= tank.alive ? conv_sample : 12'h000;
            end
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence conv_end_s;
        conv_ok;
    endsequence

    sequence read_drive1_s;
        arvalid && arready && ar_idx == idx_drive0 + 6'h01;
    endsequence

    boost_single_a: assert property (
        ctrl.multi |=> !boosted_drive_ch0)
        else $error("boost driven in multi-channel mode");

    act_full_a: assert property (
        next_phase == ph_settle && !cfg.act_sel |=> drive_code == code_full)
        else $error("activation not at full current");

    calib_source_a: assert property (
        next_phase == ph_convert && !cfg.override |=> drive_code == $past(work_cur))
        else $error("calibration not driving working code");

    fixed_code_a: assert property (
        next_phase == ph_convert && cfg.amp_dis && cfg.override
        |=> drive_code == $past(prog_cur))
        else $error("fixed drive code not applied");

    init_hold_a: assert property (
        !(conv_ok && !cfg.override) |=> $stable(init_flat))
        else $error("initial drive changed outside calibration");

    init_store_a: assert property (
        conv_end_s ##0 !cfg.override |=> init_code[$past(conv_channel)] == $past(work_cur))
        else $error("initial drive not stored at conversion end");

    drive_map_a: assert property (
        read_drive1_s |=> rvalid && rresp == resp_okay
        && rdata[15:11] == $past(prog_code[1]))
        else $error("drive register one not at its address");

    mono_ua_a: assert property (
        drive_code > $past(drive_code) |-> applied_ua > $past(applied_ua))
        else $error("current not monotonic in code");

    dead_zero_a: assert property (
        conv_end_s ##0 !tank.alive |=> sample_valid && sample_data == 12'h000)
        else $error("dead oscillator gave nonzero sample");

    sleep_quiet_a: assert property (
        ctrl.sleep |=> !drive_enable && !sample_valid && sample_data == 12'h000)
        else $error("activity during sleep");

    cfg_keep_a: assert property (
        ctrl.sleep && !(wr_go && wr_idx == idx_config) |=> $stable(cfg_word))
        else $error("configuration lost in sleep");

endmodule

// *** hw/sync3.sv ***
// Purpose: three-stage synchroniser for asynchronous level inputs
// Assumes: inputs are slow levels from the analog side
// Notes:   output follows only once stages two and three agree

`timescale 1ns/1ps

module sync3 #(
    parameter int width = 3
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // levels
    input wire logic [width-1:0] async_in,
    output logic [width-1:0] sync_out
);

    logic [width-1:0] stage1;
    logic [width-1:0] stage2;
    logic [width-1:0] stage3;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            // a lone metastable sample in stage two cannot reach the output
            if (stage2 == stage3) begin
                sync_out <= stage3;
            end
        end
    end

endmodule

// *** tb/drive_current_ctrl_tb.sv ***
// Purpose: self-checking bench for the sensor drive current control
// Assumes: bready and rready stay high; full word strobes
// Notes:   bus tasks wait on the handshake; the watchdog cuts a hang short

`timescale 1ns/1ps

module drive_current_ctrl_tb import drive_ctrl_pkg::*; ;
    logic aclk, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0, bready = 1, rready = 1;
    logic conv_settling = 0, conv_done = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] conv_channel = 0, bresp, rresp, sample_channel;
    logic [11:0] conv_sample = 0, sample_data;
    logic [4:0] target = 5'h10, dead_below = 5'h00, drive_code;
    logic awready, wready, arready, bvalid, rvalid, sleep_mode, sample_valid;
    logic drive_enable, boosted_drive_ch0, amp_above_max, amp_below_min, osc_alive;
    int error_cnt = 0, check_count = 0;

    drive_current_ctrl drive_current_ctrl_inst (.*);
    sensor_tank_model sensor_tank_model_inst (.*);

    initial begin
        aclk = 0;
        forever #4 aclk = ~aclk;
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [5:0] i, input logic [31:0] d, input logic [1:0] r);
        awaddr <= {i, 2'h0};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk(bresp, r);
    endtask

    task automatic rc(input logic [5:0] i, input logic [31:0] e, input logic [1:0] r);
        araddr <= {i, 2'h0};
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        chk(rdata, e);
        chk(rresp, r);
    endtask

    // one conversion; waits first so the tank flags settle through the synchroniser
    task automatic pulse(input logic [1:0] c, input logic [11:0] s, input logic v,
                         input logic [11:0] e);
        conv_channel <= c;
        conv_sample <= s;
        repeat (6) @(posedge aclk);
        conv_done <= 1'b1;
        @(posedge aclk);
        conv_done <= 1'b0;
        #1;
        chk(sample_valid, v);
        chk(sample_data, e);
        @(posedge aclk);
    endtask

    task automatic settle();
        repeat (3) @(posedge aclk);
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        wrap_up();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(idx_config, 32'h0, resp_okay);
        rc(idx_control, 32'h1, resp_okay);
        rc(6'h30, 32'h0, resp_decerr);
        wr(6'h30, 32'hffff, resp_decerr);
        for (int i = 0; i < 4; i++) begin
            wr(idx_drive0 + 6'(i), 32'h07c0 | ((i + 5) << 11), resp_okay);
        end
        for (int i = 0; i < 4; i++) begin
            rc(idx_drive0 + 6'(i), (i + 5) << 11, resp_okay);
        end
        wr(idx_config, 32'h1c00, resp_okay);
        wr(idx_control, 32'h0, resp_okay);
        conv_channel <= 2'h2;
        conv_settling <= 1'b1;
        settle();
        chk(drive_code, 32'h7);
        chk(drive_enable, 32'h1);
        chk(sleep_mode, 32'h0);
        conv_settling <= 1'b1;
        wr(idx_config, 32'h1400, resp_okay);
        settle();
        chk(drive_code, 32'h1f);
        conv_settling <= 1'b0;
        wr(idx_config, 32'h1440, resp_okay);
        conv_channel <= 2'h0;
        settle();
        chk(boosted_drive_ch0, 32'h1);
        wr(idx_control, 32'h2, resp_okay);
        settle();
        chk(boosted_drive_ch0, 32'h0);
        wr(idx_control, 32'h0, resp_okay);
        dead_below <= 5'h06;
        pulse(2'h0, 12'habc, 1'b1, 12'h000);
        dead_below <= 5'h00;
        pulse(2'h0, 12'habc, 1'b1, 12'habc);
        wr(idx_control, 32'h1, resp_okay);
        pulse(2'h0, 12'h123, 1'b0, 12'h000);
        chk(drive_enable, 32'h0);
        chk(sleep_mode, 32'h1);
        rc(idx_config, 32'h1440, resp_okay);
        // calibration selected in sleep, then woken and run
        wr(idx_config, 32'h0, resp_okay);
        target <= 5'h09;
        wr(idx_control, 32'h0, resp_okay);
        repeat (12) pulse(2'h1, 12'h155, 1'b1, 12'h155);
        chk(sample_channel, 32'h1);
        rc(idx_sample, 32'h1155, resp_okay);
        rc(idx_drive0 + 6'h1, (6 << 11) | (9 << 6), resp_okay);
        rc(idx_status, 32'h10769, resp_okay);
        wr(idx_drive0 + 6'h1, 9 << 11, resp_okay);
        wr(idx_config, 32'h1400, resp_okay);
        target <= 5'h14;
        pulse(2'h1, 12'h155, 1'b1, 12'h155);
        chk(drive_code, 32'h9);
        wr(idx_config, 32'h1000, resp_okay);
        repeat (14) pulse(2'h1, 12'h0aa, 1'b1, 12'h0aa);
        chk(drive_code, 32'h14);
        wrap_up();
    end
endmodule

// *** tb/sensor_tank_model.sv ***
// Purpose: behavioural LC sensor tank that answers the drive current
// Assumes: swing grows with drive code; the target code lands inside the window
// Notes:   flags are plain levels, the design synchronises them itself

`timescale 1ns/1ps

module sensor_tank_model (
    // drive from the device
    input wire logic [4:0] drive_code,
    input wire logic drive_enable,
    input wire logic boosted_drive_ch0,
    // bench knobs: code that sits mid-window, code below which the tank stalls
    input wire logic [4:0] target,
    input wire logic [4:0] dead_below,
    // amplitude flags
    output logic amp_above_max,
    output logic amp_below_min,
    output logic osc_alive
);
    // ****************************************
    // amplitude
    // ****************************************
    always_comb begin
        // too little current stalls the tank outright
        osc_alive = drive_enable && drive_code >= dead_below;
        // more current gives more swing; boost overshoots whenever the tank is alive
        amp_above_max = osc_alive && (drive_code > target || boosted_drive_ch0);
        amp_below_min = !osc_alive || drive_code < target;
    end
endmodule
